// ==== src/mit_regs.vh ====
/*
 * constants for the instruction timing sequencer: opcode codes, field positions,
 * addresses and reset values.
 * assumes a 16-bit instruction word of {opcode[15:11], bit index[10:8], operand[7:0]}.
 */
// Function
// - copy instructions take one instruction cycle and leave flags alone.
// - clear or set bit 0..7 of a memory byte in one cycle, flags unchanged.
// - branch, invoke, exits and interrupt exit take two cycles, flags unchanged.
// - skip when memory byte is zero; loading variant copies byte into working register.
// - bit test skips on bit zero or on bit one, one cycle base.
// - increment or decrement skip writes memory back, skips on zero, both penalties.
// - working-register result variants skip on zero, one cycle base.
// - current-page table fetch loads memory and table high byte in two cycles.
// - last-page table fetch loads memory and table high byte in two cycles.
// - nibble exchange swaps a memory byte in place in one cycle.
// - nibble exchange to working register leaves memory unchanged, one cycle.
// - preclear pair clears timeout and powerdown flags only when watchdog is cleared.
// - power-down entry takes one cycle and updates timeout and powerdown flags.
// - a program counter low write adds one instruction cycle of four clocks.
// - a taken skip adds one instruction cycle; no skip adds nothing.
// - watchdog clear zeroes the watchdog and clears both flags.
// - power-down stops execution, keeps state, clears watchdog, sets powerdown, clears timeout.
`ifndef MIT_REGS_VH
`define MIT_REGS_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MIT_CLKS_PER_CYCLE 4
`define MIT_PHASE_EXEC 2'h2
`define MIT_PHASE_LAST 2'h3

// ---------------------------------------------------------------
// instruction fields
// ---------------------------------------------------------------
`define MIT_OP_HI 15
`define MIT_OP_LO 11
`define MIT_BIT_HI 10
`define MIT_BIT_LO 8
`define MIT_ARG_HI 7
`define MIT_ARG_LO 0
`define MIT_TGT_HI 10

// ---------------------------------------------------------------
// addresses and reset values
// ---------------------------------------------------------------
`define MIT_PC_LOW_ADDR 8'h02
`define MIT_LAST_PAGE 8'hff
`define MIT_RST_BYTE 8'h00

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define MIT_OP_IDLE 5'h00
`define MIT_OP_CPY_MA 5'h01
`define MIT_OP_CPY_AM 5'h02
`define MIT_OP_CPY_AI 5'h03
`define MIT_OP_CLR_BIT 5'h04
`define MIT_OP_SET_BIT 5'h05
`define MIT_OP_BRANCH 5'h06
`define MIT_OP_INVOKE 5'h07
`define MIT_OP_EXIT 5'h08
`define MIT_OP_EXIT_IMM 5'h09
`define MIT_OP_INT_EXIT 5'h0a
`define MIT_OP_SKZ 5'h0b
`define MIT_OP_SKZ_LOAD 5'h0c
`define MIT_OP_SKB_CLR 5'h0d
`define MIT_OP_SKB_SET 5'h0e
`define MIT_OP_INC_SKZ 5'h0f
`define MIT_OP_DEC_SKZ 5'h10
`define MIT_OP_INC_A_SKZ 5'h11
`define MIT_OP_DEC_A_SKZ 5'h12
`define MIT_OP_TAB_CUR 5'h13
`define MIT_OP_TAB_LAST 5'h14
`define MIT_OP_CLR_BYTE 5'h15
`define MIT_OP_SET_BYTE 5'h16
`define MIT_OP_WD_CLR 5'h17
`define MIT_OP_WD_PRE1 5'h18
`define MIT_OP_WD_PRE2 5'h19
`define MIT_OP_SWAP 5'h1a
`define MIT_OP_SWAP_A 5'h1b
`define MIT_OP_HALT 5'h1c

`endif

// ==== src/mit_byte_unit.v ====
/*
 * byte unit: computes the data result, the write targets and the skip decision
 * of one instruction from the memory byte and the working register.
 * assumes pure combinational use inside the sequencer.
 */
`timescale 1ns/1ps
`include "mit_regs.vh"

module mit_byte_unit (
  // instruction
  input wire [4:0] op_in,
  input wire [2:0] bit_in,
  input wire [7:0] arg_in,
  // operands
  input wire [7:0] mem_in,
  input wire [7:0] work_in,
  // results
  output reg [7:0] res_out,
  output reg wr_mem_out,
  output reg wr_acc_out,
  output reg skip_out
);

  wire [7:0] inc_val = mem_in + 8'h01;
  wire [7:0] dec_val = mem_in - 8'h01;
  wire [7:0] swp_val = {mem_in[3:0], mem_in[7:4]};
  wire [7:0] bit_mask = 8'h01 << bit_in;

  // result and destination decode; nothing here touches a status flag
  always @* begin
    res_out = mem_in;
    wr_mem_out = 1'b0;
    wr_acc_out = 1'b0;
    skip_out = 1'b0;
    case (op_in)
      `MIT_OP_CPY_MA: begin
        wr_acc_out = 1'b1;
      end
      `MIT_OP_CPY_AM: begin
        res_out = work_in;
        wr_mem_out = 1'b1;
      end
      `MIT_OP_CPY_AI, `MIT_OP_EXIT_IMM: begin
        res_out = arg_in;
        wr_acc_out = 1'b1;
      end
      `MIT_OP_CLR_BIT: begin
        res_out = mem_in & ~bit_mask;
        wr_mem_out = 1'b1;
      end
      `MIT_OP_SET_BIT: begin
        res_out = mem_in | bit_mask;
        wr_mem_out = 1'b1;
      end
      `MIT_OP_SKZ: begin
        skip_out = (mem_in == 8'h00);
      end
      `MIT_OP_SKZ_LOAD: begin
        wr_acc_out = 1'b1;
        skip_out = (mem_in == 8'h00);
      end
      `MIT_OP_SKB_CLR: begin
        skip_out = ~mem_in[bit_in];
      end
      `MIT_OP_SKB_SET: begin
        skip_out = mem_in[bit_in];
      end
      `MIT_OP_INC_SKZ, `MIT_OP_INC_A_SKZ: begin
        res_out = inc_val;
        wr_mem_out = (op_in == `MIT_OP_INC_SKZ);
        wr_acc_out = (op_in == `MIT_OP_INC_A_SKZ);
        skip_out = (inc_val == 8'h00);
      end
      `MIT_OP_DEC_SKZ, `MIT_OP_DEC_A_SKZ: begin
        res_out = dec_val;
        wr_mem_out = (op_in == `MIT_OP_DEC_SKZ);
        wr_acc_out = (op_in == `MIT_OP_DEC_A_SKZ);
        skip_out = (dec_val == 8'h00);
      end
      `MIT_OP_CLR_BYTE: begin
        res_out = 8'h00;
        wr_mem_out = 1'b1;
      end
      `MIT_OP_SET_BYTE: begin
        res_out = 8'hff;
        wr_mem_out = 1'b1;
      end
      `MIT_OP_SWAP: begin
        res_out = swp_val;
        wr_mem_out = 1'b1;
      end
      `MIT_OP_SWAP_A: begin
        res_out = swp_val;
        wr_acc_out = 1'b1;
      end
      default: begin
        res_out = mem_in;
      end
    endcase
  end

endmodule // mit_byte_unit

// ==== src/mit_sequencer.v ====
/*
 * instruction sequencer: fetches, times and executes data move, bit, branch,
 * skip, table fetch and miscellaneous instructions, four clocks per cycle.
 * assumes program rom and data memory answer combinationally to the address
 * outputs within one clock, and that the data memory writes on a clock edge
 * while its write enable is high.
 */
`timescale 1ns/1ps
`include "mit_regs.vh"

module mit_sequencer #(
  parameter PC_W = 16,
  parameter STACK_D = 8,
  parameter SP_W = 3
) (
  // clock and reset
  input wire SYS_CLK_IN,
  input wire RESETN_IN,
  // program rom
  output reg [PC_W-1:0] ROM_ADDR_OUT,
  input wire [15:0] ROM_DATA_IN,
  // data memory
  output reg [7:0] DM_ADDR_OUT,
  output reg [7:0] DM_WDATA_OUT,
  output reg DM_WE_OUT,
  input wire [7:0] DM_RDATA_IN,
  // table pointer from core
  input wire [7:0] TABLE_PTR_IN,
  // watchdog and power-down
  input wire WATCHDOG_TIMEOUT_IN,
  input wire WAKE_IN,
  output reg WATCHDOG_CLEAR_OUT,
  output reg HALT_OUT,
  output reg TIMEOUT_FLAG_OUT,
  output reg POWERDOWN_FLAG_OUT,
  // core state
  output reg [7:0] WORK_REG_OUT,
  output reg [7:0] TABLE_HIGH_OUT,
  output reg INT_RESTORE_OUT
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [1:0] phase_reg;
  reg [1:0] extra_reg;
  reg first_reg;
  reg tab_reg;
  reg [15:0] instr_reg;
  reg [PC_W-1:0] pc_reg;
  reg [SP_W-1:0] sp_reg;
  reg [PC_W-1:0] stack_mem [0:STACK_D-1];
  reg pre1_reg;
  reg pre2_reg;
  reg [2:0] wake_sync_reg;

  wire [4:0] op = instr_reg[`MIT_OP_HI:`MIT_OP_LO];
  wire [7:0] arg = instr_reg[`MIT_ARG_HI:`MIT_ARG_LO];
  wire [PC_W-1:0] pc_inc = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
  wire [PC_W-1:0] pc_skip = pc_reg + {{(PC_W-2){1'b0}}, 2'h2};
  wire [PC_W-1:0] pc_tgt = {pc_reg[PC_W-1:`MIT_TGT_HI+1], instr_reg[`MIT_TGT_HI:0]};
  wire [SP_W-1:0] sp_up = sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
  wire [SP_W-1:0] sp_dn = sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
  wire exec = first_reg && (phase_reg == `MIT_PHASE_EXEC);
  wire tab_cap = tab_reg && (phase_reg == `MIT_PHASE_EXEC);
  wire cycle_end = (phase_reg == `MIT_PHASE_LAST);
  wire wake = wake_sync_reg[1] && wake_sync_reg[2];

  wire [7:0] res;
  wire wr_mem;
  wire wr_acc;
  wire skip;

  // ---------------------------------------------------------------
  // data path
  // ---------------------------------------------------------------
  mit_byte_unit u_byte (
    .op_in(op),
    .bit_in(instr_reg[`MIT_BIT_HI:`MIT_BIT_LO]),
    .arg_in(arg),
    .mem_in(DM_RDATA_IN),
    .work_in(WORK_REG_OUT),
    .res_out(res),
    .wr_mem_out(wr_mem),
    .wr_acc_out(wr_acc),
    .skip_out(skip)
  );

  wire pc_low_hit = wr_mem && (arg == `MIT_PC_LOW_ADDR);
  wire tab_pc_low = (arg == `MIT_PC_LOW_ADDR);
  wire two_cyc = (op == `MIT_OP_BRANCH) || (op == `MIT_OP_INVOKE) || (op == `MIT_OP_EXIT) ||
                 (op == `MIT_OP_EXIT_IMM) || (op == `MIT_OP_INT_EXIT);
  wire is_tab = (op == `MIT_OP_TAB_CUR) || (op == `MIT_OP_TAB_LAST);
  wire pre_done = ((op == `MIT_OP_WD_PRE1) && pre2_reg) || ((op == `MIT_OP_WD_PRE2) && pre1_reg);
  wire wd_clear = (op == `MIT_OP_WD_CLR) || pre_done || (op == `MIT_OP_HALT);

  // extra instruction cycles beyond the first
  wire [1:0] extra_next = (two_cyc ? 2'h1 : 2'h0) +
                          (is_tab ? 2'h1 : 2'h0) +
                          (skip ? 2'h1 : 2'h0) +
                          ((pc_low_hit || (is_tab && tab_pc_low)) ? 2'h1 : 2'h0);

  // program counter after the first cycle
  reg [PC_W-1:0] pc_next;
  always @* begin
    pc_next = pc_inc;
    case (op)
      `MIT_OP_BRANCH, `MIT_OP_INVOKE: begin
        pc_next = pc_tgt;
      end
      `MIT_OP_EXIT, `MIT_OP_EXIT_IMM, `MIT_OP_INT_EXIT: begin
        pc_next = stack_mem[sp_dn];
      end
      default: begin
        if (skip) begin
          pc_next = pc_skip;
        end
        if (pc_low_hit) begin
          pc_next = {pc_reg[PC_W-1:8], res};
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // wake pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wake_sync_reg <= 3'h0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], WAKE_IN};
    end
  end

  // ---------------------------------------------------------------
  // cycle timing: phase counter, fetch, extra cycles
  // ---------------------------------------------------------------
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      phase_reg <= 2'h0;
      extra_reg <= 2'h0;
      first_reg <= 1'b0;
      tab_reg <= 1'b0;
      instr_reg <= 16'h0000;
    end else if (!HALT_OUT) begin
      phase_reg <= phase_reg + 2'h1;
      if (exec) begin
        first_reg <= 1'b0;
        extra_reg <= extra_next;
        tab_reg <= is_tab;
      end else if (tab_cap) begin
        tab_reg <= 1'b0;
      end
      if (cycle_end && !first_reg) begin
        if (extra_reg != 2'h0) begin
          extra_reg <= extra_reg - 2'h1;
        end else if (!(exec && (op == `MIT_OP_HALT))) begin
          instr_reg <= ROM_DATA_IN;
          first_reg <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // execution: program counter, stack, memory and register writes
  // ---------------------------------------------------------------
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pc_reg <= {PC_W{1'b0}};
      ROM_ADDR_OUT <= {PC_W{1'b0}};
      sp_reg <= {SP_W{1'b0}};
      DM_ADDR_OUT <= `MIT_RST_BYTE;
      DM_WDATA_OUT <= `MIT_RST_BYTE;
      DM_WE_OUT <= 1'b0;
      WORK_REG_OUT <= `MIT_RST_BYTE;
      TABLE_HIGH_OUT <= `MIT_RST_BYTE;
      INT_RESTORE_OUT <= 1'b0;
    end else begin
      DM_WE_OUT <= 1'b0;
      INT_RESTORE_OUT <= 1'b0;
      // operand address follows the fetched word
      if (cycle_end && !first_reg && extra_reg == 2'h0 && !HALT_OUT) begin
        DM_ADDR_OUT <= ROM_DATA_IN[`MIT_ARG_HI:`MIT_ARG_LO];
      end
      if (exec && !HALT_OUT) begin
        pc_reg <= pc_next;
        ROM_ADDR_OUT <= pc_next;
        DM_WDATA_OUT <= res;
        DM_WE_OUT <= wr_mem;
        if (wr_acc) begin
          WORK_REG_OUT <= res;
        end
        if (op == `MIT_OP_INVOKE) begin
          stack_mem[sp_reg] <= pc_inc;
          sp_reg <= sp_up;
        end
        if ((op == `MIT_OP_EXIT) || (op == `MIT_OP_EXIT_IMM) || (op == `MIT_OP_INT_EXIT)) begin
          sp_reg <= sp_dn;
        end
        INT_RESTORE_OUT <= (op == `MIT_OP_INT_EXIT);
        // table fetch drives the table address for its second cycle
        if (op == `MIT_OP_TAB_CUR) begin
          ROM_ADDR_OUT <= {pc_reg[PC_W-1:8], TABLE_PTR_IN};
        end else if (op == `MIT_OP_TAB_LAST) begin
          ROM_ADDR_OUT <= {{(PC_W-8){1'b1}}, TABLE_PTR_IN};
        end
      end
      // second table cycle: low byte to memory, high byte to table register
      if (tab_cap && !HALT_OUT) begin
        DM_WDATA_OUT <= ROM_DATA_IN[7:0];
        DM_WE_OUT <= 1'b1;
        TABLE_HIGH_OUT <= ROM_DATA_IN[15:8];
        if (tab_pc_low) begin
          pc_reg <= {pc_reg[PC_W-1:8], ROM_DATA_IN[7:0]};
          ROM_ADDR_OUT <= {pc_reg[PC_W-1:8], ROM_DATA_IN[7:0]};
        end else begin
          ROM_ADDR_OUT <= pc_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // watchdog clearing, flags and power-down
  // ---------------------------------------------------------------
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pre1_reg <= 1'b0;
      pre2_reg <= 1'b0;
      WATCHDOG_CLEAR_OUT <= 1'b0;
      HALT_OUT <= 1'b0;
      TIMEOUT_FLAG_OUT <= 1'b0;
      POWERDOWN_FLAG_OUT <= 1'b0;
    end else begin
      WATCHDOG_CLEAR_OUT <= 1'b0;
      if (exec && !HALT_OUT) begin
        if (op == `MIT_OP_WD_PRE1) begin
          pre1_reg <= ~pre_done;
          pre2_reg <= 1'b0;
        end else if (op == `MIT_OP_WD_PRE2) begin
          pre2_reg <= ~pre_done;
          pre1_reg <= 1'b0;
        end
        if (wd_clear) begin
          WATCHDOG_CLEAR_OUT <= 1'b1;
          TIMEOUT_FLAG_OUT <= 1'b0;
          POWERDOWN_FLAG_OUT <= (op == `MIT_OP_HALT);
        end
        if (op == `MIT_OP_HALT) begin
          HALT_OUT <= 1'b1;
        end
      end
      // a timeout in the clearing cycle still lands
      if (WATCHDOG_TIMEOUT_IN) begin
        TIMEOUT_FLAG_OUT <= 1'b1;
      end
      if (HALT_OUT && (wake || WATCHDOG_TIMEOUT_IN)) begin
        HALT_OUT <= 1'b0;
      end
    end
  end

endmodule // mit_sequencer

// ==== sim/mit_seq_chk.sv ====
/* checker for the sequencer: pacing and flag relations at its ports.
   assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module mit_seq_chk #(
  parameter PC_W = 16
) (
  // clock and reset
  input wire SYS_CLK_IN,
  input wire RESETN_IN,
  // watched ports
  input wire [PC_W-1:0] ROM_ADDR_OUT,
  input wire DM_WE_OUT,
  input wire WATCHDOG_TIMEOUT_IN,
  input wire WATCHDOG_CLEAR_OUT,
  input wire HALT_OUT,
  input wire TIMEOUT_FLAG_OUT,
  input wire POWERDOWN_FLAG_OUT,
  input wire [7:0] WORK_REG_OUT,
  input wire [7:0] TABLE_HIGH_OUT,
  input wire INT_RESTORE_OUT
);
  // ---------------------------------------------
  // instruction pacing
  // ---------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // no instruction is shorter than four clocks
  a_rom_pace: assert property ($changed(ROM_ADDR_OUT) |=> $stable(ROM_ADDR_OUT) [*3])
    else $error("rom address moved within one cycle");
  a_work_pace: assert property ($changed(WORK_REG_OUT) |=> $stable(WORK_REG_OUT) [*3])
    else $error("working register moved within one cycle");
  a_write_pace: assert property (DM_WE_OUT |=> !DM_WE_OUT [*3])
    else $error("two memory writes within one cycle");
  a_int_pace: assert property (INT_RESTORE_OUT |=> !INT_RESTORE_OUT [*7])
    else $error("interrupt exit shorter than two cycles");
  // ---------------------------------------------
  // watchdog and power-down flags
  // ---------------------------------------------
  a_halt_entry: assert property ($rose(HALT_OUT) |-> POWERDOWN_FLAG_OUT && WATCHDOG_CLEAR_OUT &&
    (!TIMEOUT_FLAG_OUT || $past(WATCHDOG_TIMEOUT_IN)))
    else $error("power-down entry flags wrong");
  a_halt_frozen: assert property (HALT_OUT && $past(HALT_OUT) |->
    $stable(ROM_ADDR_OUT) && $stable(WORK_REG_OUT) && !DM_WE_OUT)
    else $error("sequencer moved while halted");
  a_clr_flags: assert property (WATCHDOG_CLEAR_OUT && !$past(WATCHDOG_TIMEOUT_IN) |->
    !TIMEOUT_FLAG_OUT && (HALT_OUT || !POWERDOWN_FLAG_OUT))
    else $error("watchdog clear left a flag set");
  a_to_fall: assert property ($fell(TIMEOUT_FLAG_OUT) |-> WATCHDOG_CLEAR_OUT)
    else $error("timeout flag fell without a watchdog clear");
  a_pd_rise: assert property ($rose(POWERDOWN_FLAG_OUT) |-> HALT_OUT)
    else $error("powerdown flag rose outside power-down");
  a_to_set: assert property (WATCHDOG_TIMEOUT_IN |=> TIMEOUT_FLAG_OUT)
    else $error("timeout flag not set");
  // main scenarios
  c_halt: cover property ($rose(HALT_OUT));
  c_int: cover property (INT_RESTORE_OUT);
  c_clr: cover property (WATCHDOG_CLEAR_OUT && !HALT_OUT);
  c_table: cover property ($changed(TABLE_HIGH_OUT));
endmodule // mit_seq_chk

bind mit_sequencer mit_seq_chk #(.PC_W(PC_W)) i_mit_seq_chk (.SYS_CLK_IN(SYS_CLK_IN),
  .RESETN_IN(RESETN_IN), .ROM_ADDR_OUT(ROM_ADDR_OUT), .DM_WE_OUT(DM_WE_OUT),
  .WATCHDOG_TIMEOUT_IN(WATCHDOG_TIMEOUT_IN), .WATCHDOG_CLEAR_OUT(WATCHDOG_CLEAR_OUT), .HALT_OUT(HALT_OUT),
  .TIMEOUT_FLAG_OUT(TIMEOUT_FLAG_OUT), .POWERDOWN_FLAG_OUT(POWERDOWN_FLAG_OUT),
  .WORK_REG_OUT(WORK_REG_OUT), .TABLE_HIGH_OUT(TABLE_HIGH_OUT), .INT_RESTORE_OUT(INT_RESTORE_OUT));

// ==== sim/mit_mem_model.sv ====
/* program rom and data memory standing beside the sequencer.
   assumes one clock; reads answer at once, writes land at the edge. */
`timescale 1ns/1ps
module mit_mem_model (
  // clock
  input wire clk_in,
  // program rom
  input wire [15:0] rom_addr_in,
  output wire [15:0] rom_data_out,
  // data memory
  input wire [7:0] dm_addr_in,
  input wire [7:0] dm_wdata_in,
  input wire dm_we_in,
  output wire [7:0] dm_rdata_out
);
  reg [15:0] rom [0:65535];
  reg [7:0] dm [0:255];
  integer k;
  // unprogrammed rom reads as the idle instruction
  initial begin
    for (k = 0; k < 65536; k = k + 1) rom[k] = 16'h0000;
  end
  // combinational reads
  assign rom_data_out = rom[rom_addr_in];
  assign dm_rdata_out = dm[dm_addr_in];
  // write lands at the edge that sees the strobe
  always @(posedge clk_in) begin
    if (dm_we_in) dm[dm_addr_in] <= dm_wdata_in;
  end
endmodule // mit_mem_model

// ==== sim/tb_top.sv ====
/* bench for the sequencer: short programs, exact cycle and effect checks.
   assumes the memory model and checker are compiled first. */
`timescale 1ns/1ps
`include "mit_regs.vh"
module tb_top;
  // ---------------------------------------------
  // signals and instances
  // ---------------------------------------------
  reg clk, rst_n, wd_to, wake;
  reg [7:0] tptr;
  wire [15:0] raddr, rdata;
  wire [7:0] daddr, dwd, drd, work, thigh;
  wire dwe, wclr, halt, tof, pdn, irest;
  integer bad_count, n_tests, ecnt, tick, i, s, m;
  localparam [15:0] mk = {`MIT_OP_CPY_AI, 3'h0, 8'h5a};
  mit_sequencer i_mit_sequencer (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .ROM_ADDR_OUT(raddr),
    .ROM_DATA_IN(rdata), .DM_ADDR_OUT(daddr), .DM_WDATA_OUT(dwd), .DM_WE_OUT(dwe),
    .DM_RDATA_IN(drd), .TABLE_PTR_IN(tptr), .WATCHDOG_TIMEOUT_IN(wd_to), .WAKE_IN(wake),
    .WATCHDOG_CLEAR_OUT(wclr), .HALT_OUT(halt), .TIMEOUT_FLAG_OUT(tof), .POWERDOWN_FLAG_OUT(pdn),
    .WORK_REG_OUT(work), .TABLE_HIGH_OUT(thigh), .INT_RESTORE_OUT(irest));
  mit_mem_model i_mit_mem_model (.clk_in(clk), .rom_addr_in(raddr), .rom_data_out(rdata),
    .dm_addr_in(daddr), .dm_wdata_in(dwd), .dm_we_in(dwe), .dm_rdata_out(drd));
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // edges since reset release, and the run ceiling
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) ecnt <= 0;
    else ecnt <= ecnt + 1;
  end
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == 6000) begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task end_sim;
    begin
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp1(input got, input exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task upto(input integer k);
    while (ecnt < k) @(negedge clk);
  endtask
  // working register just before and at edge k
  task tchk(input integer k, input [7:0] pre, input [7:0] post);
    begin
      upto(k - 1);
      cmp8(work, pre);
      upto(k);
      cmp8(work, post);
    end
  endtask
  task ld(input [15:0] a, input [15:0] w);
    i_mit_mem_model.rom[a] = w;
  endtask
  task dms(input [7:0] a, input [7:0] v);
    i_mit_mem_model.dm[a] = v;
  endtask
  function [7:0] dmv(input [7:0] a);
    dmv = i_mit_mem_model.dm[a];
  endfunction
  // clear the program area, reset held two clocks
  task clean;
    for (i = 0; i < 16; i = i + 1) i_mit_mem_model.rom[i] = 16'h0000;
  endtask
  task boot;
    begin
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
    end
  endtask
  task to_pulse;
    begin
      upto(1);
      wd_to = 1'b1;
      upto(2);
      wd_to = 1'b0;
    end
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_copy;
    begin
      clean;
      dms(8'h40, 8'h3c);
      ld(0, {`MIT_OP_CPY_MA, 3'h0, 8'h40});
      ld(1, {`MIT_OP_CPY_AM, 3'h0, 8'h41});
      ld(2, mk);
      boot;
      tchk(7, 8'h00, 8'h3c);
      tchk(15, 8'h3c, 8'h5a);
      cmp8(dmv(8'h41), 8'h3c);
      cmp8({6'h0, tof, pdn}, 8'h00);
      clean;
      ld(0, {`MIT_OP_CPY_AI, 3'h0, 8'h06});
      ld(1, {`MIT_OP_CPY_AM, 3'h0, 8'h02});
      ld(6, mk);
      boot;
      tchk(19, 8'h06, 8'h5a);
    end
  endtask
  task t_bits;
    for (s = 0; s < 2; s = s + 1) begin
      for (m = 0; m < 8; m = m + 1) begin
        clean;
        dms(8'h50, s ? 8'h00 : 8'hff);
        ld(0, {s ? `MIT_OP_SET_BIT : `MIT_OP_CLR_BIT, m[2:0], 8'h50});
        ld(1, mk);
        boot;
        tchk(11, 8'h00, 8'h5a);
        cmp8(dmv(8'h50), s ? (8'h01 << m) : ~(8'h01 << m));
      end
    end
  endtask
  task t_branch;
    for (m = 0; m < 4; m = m + 1) begin
      clean;
      ld(0, {m == 0 ? `MIT_OP_BRANCH : `MIT_OP_INVOKE, 3'h0, 8'h05});
      ld(5, m == 0 ? mk : {m == 1 ? `MIT_OP_EXIT : m == 2 ? `MIT_OP_EXIT_IMM : `MIT_OP_INT_EXIT, 3'h0, 8'h77});
      ld(1, mk);
      boot;
      if (m == 0) begin
        tchk(15, 8'h00, 8'h5a);
      end else begin
        upto(15);
        cmp1(irest, m == 3);
        tchk(23, m == 2 ? 8'h77 : 8'h00, 8'h5a);
      end
    end
  endtask
  task sk(input [4:0] op, input [2:0] b, input [7:0] dv, input tk, input [7:0] a0, input [7:0] em);
    begin
      clean;
      dms(8'h40, dv);
      ld(0, {op, b, 8'h40});
      ld(1, {`MIT_OP_CPY_AI, 3'h0, 8'h11});
      ld(2, mk);
      boot;
      tchk(11, a0, tk ? a0 : 8'h11);
      tchk(15, tk ? a0 : 8'h11, 8'h5a);
      cmp8(dmv(8'h40), em);
    end
  endtask
  task t_skips;
    begin
      sk(`MIT_OP_SKZ, 3'h0, 8'h00, 1'b1, 8'h00, 8'h00);
      sk(`MIT_OP_SKZ, 3'h0, 8'h05, 1'b0, 8'h00, 8'h05);
      sk(`MIT_OP_SKZ_LOAD, 3'h0, 8'h09, 1'b0, 8'h09, 8'h09);
      sk(`MIT_OP_SKZ_LOAD, 3'h0, 8'h00, 1'b1, 8'h00, 8'h00);
      sk(`MIT_OP_SKB_CLR, 3'h3, 8'hf7, 1'b1, 8'h00, 8'hf7);
      sk(`MIT_OP_SKB_CLR, 3'h3, 8'h08, 1'b0, 8'h00, 8'h08);
      sk(`MIT_OP_SKB_SET, 3'h3, 8'h08, 1'b1, 8'h00, 8'h08);
      sk(`MIT_OP_SKB_SET, 3'h3, 8'hf7, 1'b0, 8'h00, 8'hf7);
      sk(`MIT_OP_INC_A_SKZ, 3'h0, 8'hff, 1'b1, 8'h00, 8'hff);
      sk(`MIT_OP_DEC_A_SKZ, 3'h0, 8'h00, 1'b0, 8'hff, 8'h00);
      sk(`MIT_OP_INC_SKZ, 3'h0, 8'hff, 1'b1, 8'h00, 8'h00);
      sk(`MIT_OP_DEC_SKZ, 3'h0, 8'h03, 1'b0, 8'h00, 8'h02);
    end
  endtask
  task t_misc;
    begin
      clean;
      dms(8'h40, 8'h3c);
      dms(8'h41, 8'h5a);
      dms(8'h42, 8'h00);
      ld(0, {`MIT_OP_SWAP, 3'h0, 8'h40});
      ld(1, {`MIT_OP_SWAP_A, 3'h0, 8'h40});
      ld(2, {`MIT_OP_IDLE, 3'h0, 8'h00});
      ld(3, {`MIT_OP_CLR_BYTE, 3'h0, 8'h41});
      ld(4, {`MIT_OP_SET_BYTE, 3'h0, 8'h42});
      ld(5, mk);
      boot;
      tchk(11, 8'h00, 8'h3c);
      upto(15);
      cmp8(raddr[7:0], 8'h03);
      tchk(27, 8'h3c, 8'h5a);
      cmp8(dmv(8'h40), 8'hc3);
      cmp8(dmv(8'h41), 8'h00);
      cmp8(dmv(8'h42), 8'hff);
    end
  endtask
  task t_table;
    begin
      clean;
      ld(16'h0030, 16'hbeef);
      ld(16'hff31, 16'h1234);
      ld(0, {`MIT_OP_TAB_CUR, 3'h0, 8'h44});
      ld(1, {`MIT_OP_TAB_LAST, 3'h0, 8'h45});
      ld(2, mk);
      boot;
      upto(10);
      cmp8(thigh, 8'h00);
      upto(12);
      cmp8(thigh, 8'hbe);
      cmp8(dmv(8'h44), 8'hef);
      // new pointer before the second fetch executes
      tptr = 8'h31;
      upto(20);
      cmp8(thigh, 8'h12);
      cmp8(dmv(8'h45), 8'h34);
      tchk(23, 8'h00, 8'h5a);
    end
  endtask
  task t_wdt;
    begin
      clean;
      ld(0, {`MIT_OP_WD_CLR, 3'h0, 8'h00});
      ld(1, mk);
      boot;
      to_pulse;
      upto(6);
      cmp1(tof, 1'b1);
      upto(7);
      cmp1(tof, 1'b0);
      cmp1(wclr, 1'b1);
      clean;
      ld(0, {`MIT_OP_WD_PRE1, 3'h0, 8'h00});
      ld(1, {`MIT_OP_WD_PRE1, 3'h0, 8'h00});
      ld(2, {`MIT_OP_WD_PRE2, 3'h0, 8'h00});
      ld(3, mk);
      boot;
      to_pulse;
      upto(11);
      cmp1(tof, 1'b1);
      upto(15);
      cmp1(tof, 1'b0);
      tchk(19, 8'h00, 8'h5a);
    end
  endtask
  task t_halt;
    begin
      clean;
      ld(0, {`MIT_OP_HALT, 3'h0, 8'h00});
      ld(1, mk);
      ld(2, {`MIT_OP_WD_CLR, 3'h0, 8'h00});
      boot;
      to_pulse;
      upto(7);
      cmp8({5'h0, halt, pdn, tof}, 8'h06);
      upto(40);
      cmp8(work, 8'h00);
      wake = 1'b1;
      m = 0;
      while (work !== 8'h5a && m < 40) begin
        @(negedge clk);
        m = m + 1;
      end
      cmp8(work, 8'h5a);
      cmp1(halt, 1'b0);
      cmp1(pdn, 1'b1);
      // watchdog clear after wake drops the powerdown flag
      upto(52);
      cmp1(pdn, 1'b0);
      cmp1(wclr, 1'b1);
      wake = 1'b0;
    end
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst_n = 1'b0;
    wd_to = 1'b0;
    wake = 1'b0;
    tptr = 8'h30;
    bad_count = 0;
    n_tests = 0;
    tick = 0;
    t_copy;
    t_bits;
    t_branch;
    t_skips;
    t_misc;
    t_table;
    t_wdt;
    t_halt;
    end_sim;
  end
endmodule // tb_top
